// [olci_chan_irq.sv]
`default_nettype none
module olci_chan_irq
(
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output var  logic                pready,
	output var  logic [31:0]         prdata,
	output var  logic                pslverr,
	// Fetch engine events, one bit per channel: luma, U/UV, V
	input  wire logic [2:0]          evt_transfer_end,
	input  wire logic [2:0]          evt_descriptor_fetched,
	input  wire logic [2:0]          evt_head_fetched,
	input  wire logic [2:0]          evt_list_end,
	input  wire logic [2:0]          evt_overflow,
	// Frame timing and queue feedback
	input  wire logic                frame_start,
	input  wire logic                frame_end,
	input  wire logic                head_added,
	// Layer control towards the fetch engine
	output var  logic                layer_enable,
	output var  logic                layer_abort_now,
	output var  logic                attribute_apply,
	output var  logic                queue_append_request,
	// Interrupt
	output var  logic                layer_irq
);
	import olci_pkg::*;

	olci_chan_e  state_r;
	olci_chan_e  state_nxt;
	logic        attr_pending_r;
	logic        setup;
	logic        acc;
	logic        wr_on;
	logic        wr_attr;
	logic        wr_append;
	logic        wr_stop;
	logic        wr_abort;
	logic        wr_irq_en;
	logic        wr_irq_dis;
	logic        isr_clr;
	logic        irq_any;
	logic [31:0] ev_vec;
	logic [31:0] clr_vec;
	logic [31:0] flags_r;
	logic [31:0] mask_r;
	logic [31:0] rd_nxt;

	function automatic logic addr_ok(input logic [31:0] a);
		return a == OFS_CH_ENABLE || a == OFS_CH_DISABLE || a == OFS_CH_STATUS
			|| a == OFS_IRQ_ENABLE || a == OFS_IRQ_DISABLE || a == OFS_IRQ_MASK
			|| a == OFS_IRQ_STATUS;
	endfunction

	function automatic logic wr_hit(input logic a, input logic w,
			input logic [31:0] ad, input logic [31:0] ofs);
		return a && w && ad == ofs;
	endfunction

	// APB phases: one wait-free access after the setup cycle
	assign setup = psel && !penable;
	assign acc   = psel && penable && pready;

	assign wr_on      = wr_hit(acc, pwrite, paddr, OFS_CH_ENABLE) && pwdata[BIT_CHAN_ON];
	assign wr_attr    = wr_hit(acc, pwrite, paddr, OFS_CH_ENABLE) && pwdata[BIT_ATTR];
	assign wr_append  = wr_hit(acc, pwrite, paddr, OFS_CH_ENABLE) && pwdata[BIT_APPEND];
	assign wr_stop    = wr_hit(acc, pwrite, paddr, OFS_CH_DISABLE) && pwdata[BIT_STOP];
	assign wr_abort   = wr_hit(acc, pwrite, paddr, OFS_CH_DISABLE) && pwdata[BIT_ABORT];
	assign wr_irq_en  = wr_hit(acc, pwrite, paddr, OFS_IRQ_ENABLE);
	assign wr_irq_dis = wr_hit(acc, pwrite, paddr, OFS_IRQ_DISABLE);
	assign isr_clr    = wr_hit(acc, !pwrite, paddr, OFS_IRQ_STATUS);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= setup;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else
			pslverr <= setup && !addr_ok(paddr);
	end

	// Place each channel's events on its source bits
	always_comb
	begin
		ev_vec = REG_RESET;
		for (int c = 0; c < N_CHAN; c++)
		begin
			// Each channel raises only its own group of flags
			ev_vec[src_bit(c, SRC_XFER_END)] = evt_transfer_end[c];
			ev_vec[src_bit(c, SRC_DESC)]     = evt_descriptor_fetched[c];
			ev_vec[src_bit(c, SRC_HEAD)]     = evt_head_fetched[c];
			ev_vec[src_bit(c, SRC_LIST_END)] = evt_list_end[c];
			ev_vec[src_bit(c, SRC_OVERFLOW)] = evt_overflow[c];
		end
	end

	assign clr_vec = {32{isr_clr}};

	olci_sticky_flags u_flags
	(
		.pclk    (pclk),
		.presetn (presetn),
		.set_vec (ev_vec),
		.clr_vec (clr_vec),
		.flags_r (flags_r)
	);

	olci_irq_mask u_mask
	(
		.pclk    (pclk),
		.presetn (presetn),
		.en_wr   (wr_irq_en),
		.dis_wr  (wr_irq_dis),
		.wdata   (pwdata),
		.mask_r  (mask_r)
	);

	// Read data is sampled in the setup cycle
	always_comb
	begin
		rd_nxt = REG_RESET;
		if (paddr == OFS_CH_STATUS)
		begin
			rd_nxt[BIT_CHAN_ON] = state_r != CH_OFF;
			rd_nxt[BIT_ATTR]    = attr_pending_r;
			rd_nxt[BIT_APPEND]  = queue_append_request;
		end
		else if (paddr == OFS_IRQ_MASK)
			rd_nxt = mask_r & IRQ_VALID;
		else if (paddr == OFS_IRQ_STATUS)
			// Include this cycle's events: they land before the clear edge
			rd_nxt = (flags_r | ev_vec) & IRQ_VALID;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= REG_RESET;
		else if (setup && !pwrite)
			prdata <= rd_nxt;
	end

	// Channel state
	always_comb
	begin
		state_nxt = state_r;
		if (wr_abort)
			state_nxt = CH_OFF;
		else if (wr_on)
			state_nxt = CH_ON;
		else
		begin
			case (state_r)
				CH_ON:
					if (wr_stop)
						state_nxt = CH_STOPPING;
				CH_STOPPING:
					if (frame_end)
						state_nxt = CH_OFF;
				default:
					state_nxt = state_r;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r      <= CH_OFF;
			layer_enable <= 1'b0;
		end
		else
		begin
			state_r      <= state_nxt;
			layer_enable <= state_nxt != CH_OFF;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			layer_abort_now <= 1'b0;
		else
			layer_abort_now <= wr_abort;
	end

	// Attribute update waits for the next frame start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			attr_pending_r <= 1'b0;
		else if (wr_attr)
			attr_pending_r <= 1'b1;
		else if (wr_abort || frame_start)
			attr_pending_r <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			attribute_apply <= 1'b0;
		else
			attribute_apply <= frame_start && attr_pending_r;
	end

	// Append request held until the engine reports the head taken or an abort is written
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			queue_append_request <= 1'b0;
		else if (wr_append)
			queue_append_request <= 1'b1;
		else if (wr_abort || head_added)
			queue_append_request <= 1'b0;
	end

	assign irq_any = |(flags_r & mask_r);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			layer_irq <= 1'b0;
		else
			layer_irq <= irq_any;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_APB_ONE_WAIT: assert property (
		setup |=> pready ##1 !pready)
		else $error("access phase not answered after one cycle");

	AST_STOP_WAITS_FRAME: assert property (
		state_r == CH_STOPPING && !frame_end && !wr_on && !wr_abort
			|=> state_r == CH_STOPPING && layer_enable)
		else $error("layer stopped before frame end");

	AST_STOP_AT_FRAME_END: assert property (
		state_r == CH_STOPPING && frame_end && !wr_on
			|=> !layer_enable ##1 (!layer_enable || $past(wr_on)))
		else $error("layer not stopped at frame end");

	AST_ABORT_NOW: assert property (
		wr_abort |=> state_r == CH_OFF && !layer_enable && layer_abort_now
			&& !queue_append_request && !attr_pending_r)
		else $error("abort did not reset layer at once");

	AST_TURN_ON: assert property (
		wr_on && !wr_abort |=> layer_enable && state_r == CH_ON)
		else $error("turn-on write did not enable channel");

	AST_APPEND_HOLDS: assert property (
		wr_append |=> queue_append_request)
		else $error("append request not raised");

	AST_APPEND_DONE: assert property (
		queue_append_request && head_added && !wr_append && !wr_abort
			|=> !queue_append_request)
		else $error("append pending not cleared after head taken");

	AST_ATTR_APPLY: assert property (
		attr_pending_r && frame_start && !wr_attr
			|=> attribute_apply && !attr_pending_r)
		else $error("attribute update not applied at frame start");

	AST_CH_STATUS_READ: assert property (
		setup && !pwrite && paddr == OFS_CH_STATUS
			|=> prdata[BIT_CHAN_ON] == ($past(state_r) != CH_OFF)
			&& prdata[BIT_ATTR] == $past(attr_pending_r))
		else $error("channel status read wrong");

	AST_READ_CLEARS: assert property (
		isr_clr && ev_vec == REG_RESET |=> flags_r == REG_RESET)
		else $error("status read did not clear flags");

	AST_IRQ_LEVEL: assert property (
		##1 layer_irq == $past(irq_any))
		else $error("interrupt output disagrees with masked flags");

	AST_IRQ_RAISED: assert property (
		(flags_r & mask_r) != REG_RESET |=> layer_irq)
		else $error("enabled flag set but interrupt low");

	AST_ATTR_PENDS: assert property (
		wr_attr |=> attr_pending_r)
		else $error("attribute update not shown as pending");

	AST_MASK_READ: assert property (
		setup && !pwrite && paddr == OFS_IRQ_MASK |=> prdata == $past(mask_r))
		else $error("mask read wrong");

	AST_APPEND_STATUS: assert property (
		setup && !pwrite && paddr == OFS_CH_STATUS
			|=> prdata[BIT_APPEND] == $past(queue_append_request))
		else $error("append pending status read wrong");

	AST_LUMA_END_SETS: assert property (
		evt_transfer_end[0] |=> flags_r[SRC_BASE + SRC_XFER_END])
		else $error("luma transfer end flag not set");

	AST_V_DESC_SETS: assert property (
		evt_descriptor_fetched[2] |=> flags_r[SRC_BASE + 2 * CHAN_STRIDE + SRC_DESC])
		else $error("V descriptor flag not set");
endmodule
`default_nettype wire

// [olci_fetch_model.sv]
`default_nettype none
module olci_fetch_model
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Commands from the bench
	input  wire logic [14:0] ev_req,
	input  wire logic [1:0]  frm_req,
	input  wire logic [4:0]  head_delay,
	// Queue request from the block
	input  wire logic        queue_append_request,
	// Events towards the block
	output var  logic [2:0]  evt_transfer_end,
	output var  logic [2:0]  evt_descriptor_fetched,
	output var  logic [2:0]  evt_head_fetched,
	output var  logic [2:0]  evt_list_end,
	output var  logic [2:0]  evt_overflow,
	output var  logic        frame_start,
	output var  logic        frame_end,
	output var  logic        head_added
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] wait_r;

	// Each commanded event becomes a one-cycle pulse
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			{evt_transfer_end, evt_descriptor_fetched, evt_head_fetched} <= '0;
			{evt_list_end, evt_overflow, frame_start, frame_end} <= '0;
		end
		else
		begin
			for (int c = 0; c < 3; c++)
			begin
				evt_transfer_end[c]       <= ev_req[5 * c];
				evt_descriptor_fetched[c] <= ev_req[5 * c + 1];
				evt_head_fetched[c]       <= ev_req[5 * c + 2];
				evt_list_end[c]           <= ev_req[5 * c + 3];
				evt_overflow[c]           <= ev_req[5 * c + 4];
			end
			frame_start <= frm_req[0];
			frame_end   <= frm_req[1];
		end
	end

	// Takes the head into the list after a chosen delay
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			head_added <= 1'b0;
			wait_r     <= '0;
		end
		else if (queue_append_request && !head_added && wait_r == head_delay)
		begin
			head_added <= 1'b1;
			wait_r     <= '0;
		end
		else
		begin
			head_added <= 1'b0;
			wait_r     <= queue_append_request && !head_added ? wait_r + 5'h01 : 5'h00;
		end
	end
endmodule
`default_nettype wire

// [olci_irq_mask.sv]
`default_nettype none
module olci_irq_mask
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Enable and disable writes
	input  wire logic        en_wr,
	input  wire logic        dis_wr,
	input  wire logic [31:0] wdata,
	// Mask state
	output var  logic [31:0] mask_r
);
	import olci_pkg::*;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_r <= REG_RESET;
		else if (en_wr)
			mask_r <= mask_r | (wdata & IRQ_VALID);
		else if (dis_wr)
			mask_r <= mask_r & ~wdata;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_EN_SETS: assert property (
		en_wr |=> mask_r == ($past(mask_r) | ($past(wdata) & IRQ_VALID)))
		else $error("enable write did not set only written bits");
	AST_DIS_CLEARS: assert property (
		dis_wr && !en_wr |=> mask_r == ($past(mask_r) & ~$past(wdata)))
		else $error("disable write did not clear only written bits");
endmodule
`default_nettype wire

// [olci_pkg.sv]
`default_nettype none
package olci_pkg;

	// Register byte addresses
	localparam logic [31:0] OFS_CH_ENABLE   = 32'hf8038280;
	localparam logic [31:0] OFS_CH_DISABLE  = 32'hf8038284;
	localparam logic [31:0] OFS_CH_STATUS   = 32'hf8038288;
	localparam logic [31:0] OFS_IRQ_ENABLE  = 32'hf803828c;
	localparam logic [31:0] OFS_IRQ_DISABLE = 32'hf8038290;
	localparam logic [31:0] OFS_IRQ_MASK    = 32'hf8038294;
	localparam logic [31:0] OFS_IRQ_STATUS  = 32'hf8038298;

	// Channel enable and channel status fields
	localparam int BIT_CHAN_ON   = 0;
	localparam int BIT_ATTR      = 1;
	localparam int BIT_APPEND    = 2;
	// Channel disable fields
	localparam int BIT_STOP      = 0;
	localparam int BIT_ABORT     = 8;

	// Interrupt source layout: channel c, source s at SRC_BASE + CHAN_STRIDE*c + s
	localparam int N_CHAN        = 3;
	localparam int N_SRC         = 5;
	localparam int SRC_BASE      = 2;
	localparam int CHAN_STRIDE   = 8;
	localparam int SRC_XFER_END  = 0;
	localparam int SRC_DESC      = 1;
	localparam int SRC_HEAD      = 2;
	localparam int SRC_LIST_END  = 3;
	localparam int SRC_OVERFLOW  = 4;

	localparam logic [31:0] IRQ_VALID  = 32'h007c7c7c;
	localparam logic [31:0] REG_RESET  = 32'h00000000;

	typedef enum logic [1:0] {CH_OFF, CH_ON, CH_STOPPING} olci_chan_e;

	function automatic int src_bit(input int ch, input int src);
		return SRC_BASE + CHAN_STRIDE * ch + src;
	endfunction

endpackage
`default_nettype wire

// [olci_sticky_flags.sv]
`default_nettype none
module olci_sticky_flags
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Set and clear requests
	input  wire logic [31:0] set_vec,
	input  wire logic [31:0] clr_vec,
	// Flag state
	output var  logic [31:0] flags_r
);
	import olci_pkg::*;

	genvar i;
	generate
		for (i = 0; i < 32; i++)
		begin : g_flag
			if (IRQ_VALID[i])
			begin : g_used
				// A new event beats a read clear in the same cycle
				always_ff @(posedge pclk or negedge presetn)
				begin
					if (!presetn)
						flags_r[i] <= REG_RESET[i];
					else
						flags_r[i] <= set_vec[i] | (flags_r[i] & ~clr_vec[i]);
				end
			end
			else
			begin : g_rsvd
				assign flags_r[i] = 1'b0;
			end
		end
	endgenerate

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_SET_WINS: assert property (
		(set_vec & IRQ_VALID) != 32'h0 |=>
			(flags_r & $past(set_vec) & IRQ_VALID) == ($past(set_vec) & IRQ_VALID))
		else $error("event lost against clear");
endmodule
`default_nettype wire

// [overlay_layer_channel_irq_ctrl_tb.sv]
`default_nettype none
module overlay_layer_channel_irq_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import olci_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata, rd, mask_m, flags_m, r;
	logic [14:0] ev_req;
	logic [1:0]  frm_req;
	logic [4:0]  head_delay;
	logic [2:0]  e_te, e_df, e_hf, e_le, e_ov;
	logic        f_s, f_e, h_a, l_en, l_ab, a_ap, q_ar, layer_irq;
	int          errors, cmp_count, cyc, abort_cnt, apply_cnt, seed;

	olci_chan_irq i_olci_chan_irq (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .evt_transfer_end(e_te),
		.evt_descriptor_fetched(e_df), .evt_head_fetched(e_hf), .evt_list_end(e_le),
		.evt_overflow(e_ov), .frame_start(f_s), .frame_end(f_e), .head_added(h_a),
		.layer_enable(l_en), .layer_abort_now(l_ab), .attribute_apply(a_ap),
		.queue_append_request(q_ar), .layer_irq(layer_irq));

	olci_fetch_model i_olci_fetch_model (.pclk(pclk), .presetn(presetn), .ev_req(ev_req),
		.frm_req(frm_req), .head_delay(head_delay), .queue_append_request(q_ar),
		.evt_transfer_end(e_te), .evt_descriptor_fetched(e_df), .evt_head_fetched(e_hf),
		.evt_list_end(e_le), .evt_overflow(e_ov), .frame_start(f_s), .frame_end(f_e),
		.head_added(h_a));

	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic test_done();
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge pclk)
	begin
		cyc++;
		abort_cnt += (l_ab === 1'b1);
		apply_cnt += (a_ap === 1'b1);
		if (cyc == 20000)
		begin
			errors++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	function automatic logic [31:0] expand(input logic [14:0] ev);
		logic [31:0] v;
		v = '0;
		for (int k = 0; k < 15; k++)
			v[2 + 8 * (k / 5) + k % 5] = ev[k];
		return v;
	endfunction

	task automatic fire(input logic [14:0] ev);
		ev_req <= ev;
		@(posedge pclk);
		ev_req <= '0;
		flags_m |= expand(ev);
		@(posedge pclk);
	endtask

	task automatic pulse_frame(input logic [1:0] f);
		frm_req <= f;
		@(posedge pclk);
		frm_req <= 2'b00;
	endtask

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, ev_req, frm_req, head_delay} = '0;
		{mask_m, flags_m} = '0;
		seed = 32'hbe86;
		presetn = 1'b0;
		tick(2);
		presetn <= 1'b1;
		tick(1);
		rdc(OFS_IRQ_MASK, 32'h0);
		rdc(OFS_IRQ_STATUS, 32'h0);
		rdc(OFS_CH_STATUS, 32'h0);
		rdc(OFS_IRQ_ENABLE, 32'h0);
		rdc(32'hf80382fc, 32'h0);
		chk(err, 1'b1);
		for (int i = 0; i < 6; i++)
		begin
			r = $random(seed);
			apb(1'b1, OFS_IRQ_ENABLE, r);
			mask_m |= r & expand(15'h7fff);
			r = $random(seed) & $random(seed);
			apb(1'b1, OFS_IRQ_DISABLE, r);
			mask_m &= ~r;
			apb(1'b1, OFS_IRQ_MASK, 32'hffffffff);
			rdc(OFS_IRQ_MASK, mask_m);
		end
		for (int k = 0; k < 15; k++)
		begin
			fire(15'h1 << k);
			rdc(OFS_IRQ_STATUS, 32'h1 << (2 + 8 * (k / 5) + k % 5));
			flags_m = '0;
			rdc(OFS_IRQ_STATUS, 32'h0);
		end
		for (int i = 0; i < 8; i++)
		begin
			fire(15'($random(seed)));
			fire(15'($random(seed)));
			tick(3);
			chk(layer_irq, |(flags_m & mask_m));
			rdc(OFS_IRQ_STATUS, flags_m);
			flags_m = '0;
			tick(3);
			chk(layer_irq, 1'b0);
		end
		apb(1'b1, OFS_CH_ENABLE, 32'h1);
		tick(2);
		chk(l_en, 1'b1);
		apb(1'b1, OFS_CH_DISABLE, 32'h1);
		tick(4);
		rdc(OFS_CH_STATUS, 32'h1);
		pulse_frame(2'b10);
		tick(3);
		chk(l_en, 1'b0);
		rdc(OFS_CH_STATUS, 32'h0);
		apb(1'b1, OFS_CH_ENABLE, 32'h3);
		rdc(OFS_CH_STATUS, 32'h3);
		pulse_frame(2'b01);
		tick(3);
		chk(apply_cnt, 1);
		rdc(OFS_CH_STATUS, 32'h1);
		apb(1'b1, OFS_CH_ENABLE, 32'h0);
		tick(2);
		chk(l_en, 1'b1);
		apb(1'b1, OFS_CH_DISABLE, 32'h100);
		tick(2);
		chk(l_en, 1'b0);
		chk(abort_cnt, 1);
		for (int d = 12; d >= 0; d -= 12)
		begin
			head_delay <= 5'(d);
			apb(1'b1, OFS_CH_ENABLE, 32'h4);
			if (d > 0)
				rdc(OFS_CH_STATUS, 32'h4);
			tick(20);
			rdc(OFS_CH_STATUS, 32'h0);
			chk(q_ar, 1'b0);
		end
		fork
			rdc(OFS_IRQ_STATUS, 32'h0);
			fire(15'h0001);
		join
		rdc(OFS_IRQ_STATUS, flags_m);
		test_done();
	end
endmodule
`default_nettype wire
